// ---- design/verdict_consts.svh ----
// constants for the handler pass/fail signalling block
// assumes a 50 MHz system clock and a plain register port
//
// Functional notes
// [RULE1] verdict line polarity selectable, negative default
// [RULE2] instrument preset leaves handler settings unchanged
// [RULE3] strobe follows settled verdict line
// [RULE4] immediate mode: fail shown at once
// [RULE5] pass-default rests pass until sweep end
// [RULE6] fail-default rests fail until sweep end
// [RULE7] ready for measurement returns line to rest
// [RULE8] all-checks policy: every check must pass
// [RULE9] every-trace policy: unchecked trace means fail
// [RULE10] scope picks channel or global report point
// [RULE11] scope ignored in immediate mode
// [RULE12] readout valid only after all sweeps done
// [RULE13] readout shows none while busy or unchecked
// [RULE14] handler reset command restores all defaults; irq mask and status keep their values
// [RULE15] sweep done line low on chosen event
// [RULE16] all handler lines driven from registers
`ifndef VERDICT_CONSTS_SVH
`define VERDICT_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_CONFIG     8'h00
`define OFS_COMMAND    8'h04
`define OFS_STATUS     8'h08
`define OFS_IRQ_STAT   8'h0c
`define OFS_IRQ_MASK   8'h10

// ****************************************************************
// config field positions
// ****************************************************************
`define CFG_POL_BIT    0
`define CFG_MODE_LO    1
`define CFG_MODE_HI    2
`define CFG_POLICY_BIT 3
`define CFG_SCOPE_BIT  4
`define CFG_SWEEP_LO   5
`define CFG_SWEEP_HI   6

// defaults: negative polarity, immediate, all checks, global, global
`define CFG_DEFAULT    7'h50
`define CMD_RESET_BIT  0

// irq bits: verdict update, sweep done
`define IRQ_VERDICT    0
`define IRQ_SWEEP      1
`define IRQ_W          2

`endif

// ---- design/verdict_pkg.sv ----
// types for the handler pass/fail signalling block
// assumes verdict_consts.svh for numeric values
package verdict_pkg;
  typedef enum logic [1:0] {mode_immediate, mode_pass_default, mode_fail_default} verdict_mode_t;
  typedef enum logic [1:0] {sweep_each, sweep_channel, sweep_global} sweep_event_t;
  typedef enum logic [1:0] {readout_none, readout_pass, readout_fail} readout_t;

  // measurement events from the sweep controller
  typedef struct packed {
    logic sweep_done;
    logic channel_done;
    logic all_done;
    logic ready_for_meas;
    logic check_fail;
    logic check_pass;
    logic trace_unchecked;
    logic any_check;
  } meas_events_t;

  // configuration fields
  typedef struct packed {
    sweep_event_t  sweep_done_event_setting;
    logic          verdict_scope_setting;  // 1 = global
    logic          verdict_policy_setting; // 1 = every trace checked
    verdict_mode_t verdict_mode_setting;
    logic          verdict_polarity_setting; // 1 = positive
  } cfg_t;
endpackage

// ---- design/handler_pass_fail.sv ----
// handler pass/fail verdict, strobe and sweep-done line driver
// assumes meas events are single-cycle pulses on clk
`timescale 1ns/1ps
`include "verdict_consts.svh"

module handler_pass_fail
  import verdict_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // register port
  input  wire logic [7:0]   addr,
  input  wire logic [31:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [31:0]  rdata,
  // measurement events
  input  wire meas_events_t ev,
  // handler lines
  output logic              pass_fail_line,
  output logic              pass_fail_strobe,
  output logic              sweep_done_n,
  output logic              irq
);

  // ****************************************************************
  // configuration
  // ****************************************************************
  cfg_t       cfg_r;
  logic       cmd_reset;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // one write strobe hitting one register offset
  function automatic logic wr_hit(input logic       strobe,
                                  input logic [7:0] a,
                                  input logic [7:0] ofs);
    return strobe && (a == ofs);
  endfunction

  logic wr_cfg;
  logic wr_cmd;
  logic wr_istat;
  logic wr_imask;

  // write decode per register, shared by the processes below
  assign wr_cfg   = wr_hit(wr, addr, `OFS_CONFIG);
  assign wr_cmd   = wr_hit(wr, addr, `OFS_COMMAND);
  assign wr_istat = wr_hit(wr, addr, `OFS_IRQ_STAT);
  assign wr_imask = wr_hit(wr, addr, `OFS_IRQ_MASK);

  // handler reset command: only bit zero of the command word acts [RULE14]
  assign cmd_reset = wr_cmd && wdata[`CMD_RESET_BIT];

  // ****************************************************************
  // configuration next value
  // ****************************************************************
  // unused mode code falls back to immediate reporting
  function automatic verdict_mode_t clamp_mode(input logic [1:0] code);
    return (code == 2'h3) ? mode_immediate : verdict_mode_t'(code);
  endfunction

  // unused sweep event code falls back to global completion
  function automatic sweep_event_t clamp_sweep(input logic [1:0] code);
    return (code == 2'h3) ? sweep_global : sweep_event_t'(code);
  endfunction

  cfg_t cfg_nxt;

  // field by field update from a config write, codes clamped
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt.verdict_polarity_setting = wdata[`CFG_POL_BIT];
      cfg_nxt.verdict_mode_setting     = clamp_mode(wdata[`CFG_MODE_HI:`CFG_MODE_LO]);
      cfg_nxt.verdict_policy_setting   = wdata[`CFG_POLICY_BIT];
      cfg_nxt.verdict_scope_setting    = wdata[`CFG_SCOPE_BIT];
      cfg_nxt.sweep_done_event_setting = clamp_sweep(wdata[`CFG_SWEEP_HI:`CFG_SWEEP_LO]);
    end
  end

  // settings kept apart from instrument preset; only srst or the handler reset command restore [RULE2] [RULE14]
  always_ff @(posedge clk) begin
    if (srst || cmd_reset)
      cfg_r <= cfg_t'(`CFG_DEFAULT);
    else
      cfg_r <= cfg_nxt;
  end

  // ****************************************************************
  // global verdict accumulation
  // ****************************************************************
  logic fail_seen_r;
  logic unchecked_r;
  logic any_check_r;
  logic busy_r;
  logic verdict_fail;
  logic report_evt;
  readout_t readout_r;

  // failure collected per measurement, cleared on ready for measurement
  always_ff @(posedge clk) begin
    if (srst || cmd_reset || ev.ready_for_meas) begin
      fail_seen_r <= 1'b0;
      unchecked_r <= 1'b0;
      any_check_r <= 1'b0;
    end else begin
      if (ev.check_fail)
        fail_seen_r <= 1'b1;
      if (ev.trace_unchecked)
        unchecked_r <= 1'b1;
      if (ev.any_check || ev.check_fail || ev.check_pass)
        any_check_r <= 1'b1;
    end
  end

  // all-checks looks only at failures; every-trace also fails unchecked traces [RULE8] [RULE9]
  assign verdict_fail = fail_seen_r || ev.check_fail ||
                        (cfg_r.verdict_policy_setting && (unchecked_r || ev.trace_unchecked));

  // scope chooses report point; unused in immediate mode [RULE10] [RULE11]
  assign report_evt = cfg_r.verdict_scope_setting ? ev.all_done : ev.channel_done;

  // busy between ready and completion of all sweeps
  always_ff @(posedge clk) begin
    if (srst || cmd_reset)
      busy_r <= 1'b0;
    else if (ev.all_done)
      busy_r <= 1'b0;
    else if (ev.ready_for_meas)
      busy_r <= 1'b1;
  end

  // readout valid after all sweeps, none while busy or unchecked [RULE12] [RULE13]
  always_ff @(posedge clk) begin
    if (srst || cmd_reset || ev.ready_for_meas)
      readout_r <= readout_none;
    else if (ev.all_done)
      readout_r <= !(any_check_r || ev.any_check || ev.check_fail || ev.check_pass) ? readout_none :
                   verdict_fail ? readout_fail : readout_pass;
  end

  // ****************************************************************
  // verdict line and strobe
  // ****************************************************************
  logic fail_lvl_r;   // logical verdict, 1 = fail
  logic rest_fail;
  logic upd_r;

  assign rest_fail = cfg_r.verdict_mode_setting == mode_fail_default;

  logic fail_lvl_nxt;
  logic upd_nxt;

  // logical fail level by mode; upd_nxt marks a reported verdict [RULE4] [RULE5] [RULE6] [RULE7]
  always_comb begin
    fail_lvl_nxt = fail_lvl_r;
    upd_nxt      = 1'b0;
    unique case (cfg_r.verdict_mode_setting)
      mode_immediate: begin
        if (ev.ready_for_meas) begin
          fail_lvl_nxt = 1'b0;
        end else if (verdict_fail && !fail_lvl_r) begin
          fail_lvl_nxt = 1'b1; // [RULE4]
          upd_nxt      = 1'b1;
        end else if (ev.all_done) begin
          upd_nxt = 1'b1;
        end
      end
      default: begin
        if (ev.ready_for_meas) begin
          fail_lvl_nxt = rest_fail; // [RULE7]
        end else if (report_evt) begin
          fail_lvl_nxt = verdict_fail; // [RULE5] [RULE6]
          upd_nxt      = 1'b1;
        end
      end
    endcase
  end

  // level and update marker registered together
  always_ff @(posedge clk) begin
    if (srst || cmd_reset) begin
      fail_lvl_r <= 1'b0;
      upd_r      <= 1'b0;
    end else begin
      fail_lvl_r <= fail_lvl_nxt;
      upd_r      <= upd_nxt;
    end
  end

  // polarity applied at the registered pin: positive high = pass [RULE1] [RULE16]
  always_ff @(posedge clk) begin
    if (srst)
      pass_fail_line <= 1'b0;
    else
      pass_fail_line <= cfg_r.verdict_polarity_setting ? !fail_lvl_r : fail_lvl_r;
  end

  // strobe one cycle after the line has changed [RULE3] [RULE16]
  logic upd_d_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      upd_d_r          <= 1'b0;
      pass_fail_strobe <= 1'b0;
    end else begin
      upd_d_r          <= upd_r;
      pass_fail_strobe <= upd_d_r;
    end
  end

  // ****************************************************************
  // sweep done line
  // ****************************************************************
  logic sweep_evt;
  always_comb begin
    unique case (cfg_r.sweep_done_event_setting)
      sweep_each:    sweep_evt = ev.sweep_done;
      sweep_channel: sweep_evt = ev.channel_done;
      default:       sweep_evt = ev.all_done;
    endcase
  end

  // active low, low after event until next measurement [RULE15] [RULE16]
  always_ff @(posedge clk) begin
    if (srst || cmd_reset)
      sweep_done_n <= 1'b1;
    else if (sweep_evt)
      sweep_done_n <= 1'b0;
    else if (ev.ready_for_meas)
      sweep_done_n <= 1'b1;
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [1:0] irq_set;
  assign irq_set = {sweep_evt, upd_r};

  logic [1:0] irq_stat_nxt;

  // sticky status, write one clears, a set in the same cycle wins
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_istat)
      irq_stat_nxt = irq_stat_r & ~wdata[`IRQ_W-1:0];
    irq_stat_nxt = irq_stat_nxt | irq_set;
  end

  // status and mask registers
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_imask)
        irq_mask_r <= wdata[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_r & irq_mask_r);
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // read data one cycle after strobe, zero otherwise and when unmapped
  always_ff @(posedge clk) begin
    if (srst || !rd) begin
      rdata <= 32'h0;
    end else begin
      unique case (addr)
        `OFS_CONFIG:   rdata <= {25'h0, cfg_r};
        `OFS_STATUS:   rdata <= {27'h0, !sweep_done_n, busy_r, fail_lvl_r, readout_r};
        `OFS_IRQ_STAT: rdata <= {30'h0, irq_stat_r};
        `OFS_IRQ_MASK: rdata <= {30'h0, irq_mask_r};
        default:       rdata <= 32'h0;
      endcase
    end
  end

endmodule

// ---- sim/handler_pass_fail_props.sv ----
// checker for the handler pass/fail lines
// assumes it is bound to handler_pass_fail and sees only its ports
`timescale 1ns/1ps
`include "verdict_consts.svh"
module handler_pass_fail_chk
  import verdict_pkg::*;
(
  // clock, reset and register port
  input wire logic         clk,
  input wire logic         srst,
  input wire logic [7:0]   addr,
  input wire logic [31:0]  wdata,
  input wire logic         wr,
  input wire logic         rd,
  input wire logic [31:0]  rdata,
  // events and handler lines
  input wire meas_events_t ev,
  input wire logic         pass_fail_line,
  input wire logic         pass_fail_strobe,
  input wire logic         sweep_done_n,
  input wire logic         irq
);
  logic [6:0] cfg_r;
  logic [1:0] md;
  logic [1:0] sw;
  // shadow of the configuration, restored by the handler reset command
  always_ff @(posedge clk) begin
    if (srst || (wr && addr == `OFS_COMMAND && wdata[0])) cfg_r <= `CFG_DEFAULT;
    else if (wr && addr == `OFS_CONFIG) cfg_r <= wdata[6:0];
  end
  assign md = (cfg_r[2:1] == 2'h3) ? 2'h0 : cfg_r[2:1];
  assign sw = (cfg_r[6:5] == 2'h3) ? 2'h2 : cfg_r[6:5];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_pass_low: assert property ($fell(srst) |-> !pass_fail_line)
    else $error("line not low after reset");
  a_fail_at_once: assert property (md == 2'h0 && ev.check_fail |-> ##2 pass_fail_line == !cfg_r[0])
    else $error("fail not shown at once");
  a_pass_rest: assert property (md == 2'h1 && ev.ready_for_meas |-> ##2 pass_fail_line == cfg_r[0])
    else $error("line not at pass rest");
  a_fail_rest: assert property (md == 2'h2 && ev.ready_for_meas |-> ##2 pass_fail_line == !cfg_r[0])
    else $error("line not at fail rest");
  a_strobe_settled: assert property ($rose(pass_fail_strobe) |-> $stable(pass_fail_line))
    else $error("strobe with moving line");
  a_scope_global: assert property (md != 2'h0 && cfg_r[4] && ev.all_done |-> ##3 pass_fail_strobe)
    else $error("no strobe at global end");
  a_scope_chan: assert property (md != 2'h0 && !cfg_r[4] && ev.channel_done |-> ##3 pass_fail_strobe)
    else $error("no strobe at channel end");
  a_sweep_low: assert property ((sw == 2'h0 && ev.sweep_done) || (sw == 2'h1 && ev.channel_done) ||
    (sw == 2'h2 && ev.all_done) |=> !sweep_done_n)
    else $error("sweep done line not low");
  a_reset_cmd: assert property (wr && addr == `OFS_COMMAND && wdata[0] |-> ##[1:2] sweep_done_n)
    else $error("handler reset left sweep line low");
  c_strobe: cover property ($rose(pass_fail_strobe));
  c_sweep: cover property ($fell(sweep_done_n));
  c_irq: cover property ($rose(irq));
endmodule
bind handler_pass_fail handler_pass_fail_chk i_chk (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .ev(ev), .pass_fail_line(pass_fail_line),
  .pass_fail_strobe(pass_fail_strobe), .sweep_done_n(sweep_done_n), .irq(irq));

// ---- sim/handler_model.sv ----
// handler side model: samples the verdict line on each strobe
// assumes the handler lines of handler_pass_fail on one clock
`timescale 1ns/1ps
module handler_model (
  // handler lines
  input  wire logic clk,
  input  wire logic pass_fail_line,
  input  wire logic pass_fail_strobe,
  input  wire logic sweep_done_n,
  // what the handler saw
  output int        n_strobe,
  output logic      verdict_pin,
  output int        n_sweep
);
  logic sweep_q = 1'b1;
  initial n_strobe = 0;
  initial n_sweep = 0;
  initial verdict_pin = 1'b0;
  // latch the settled verdict when strobed, count sweep done falls
  always @(posedge clk) begin
    sweep_q <= sweep_done_n;
    if (pass_fail_strobe) begin
      n_strobe <= n_strobe + 1;
      verdict_pin <= pass_fail_line;
    end
    if (sweep_q && !sweep_done_n) n_sweep <= n_sweep + 1;
  end
endmodule

// ---- sim/tb_handler_pass_fail.sv ----
// testbench for handler_pass_fail
// assumes the checker is bound and the handler model is beside it
`timescale 1ns/1ps
`include "verdict_consts.svh"
module tb_handler_pass_fail
  import verdict_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  meas_events_t ev = '0;
  logic [31:0] rdata;
  logic line, strobe, sdn, irq, vpin, pol, sc, pc, fl, un, exp_fail;
  logic [1:0] md;
  logic [7:0] lvl = 8'h00;
  logic [31:0] v;
  int n_strobe, n_sweep, n0, cyc, n_mismatch, n_compared;
  handler_pass_fail i_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ev(ev), .pass_fail_line(line), .pass_fail_strobe(strobe), .sweep_done_n(sdn), .irq(irq));
  handler_model i_hm (.clk(clk), .pass_fail_line(line), .pass_fail_strobe(strobe), .sweep_done_n(sdn),
    .n_strobe(n_strobe), .verdict_pin(vpin), .n_sweep(n_sweep));
  always #10 clk = ~clk;
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // one event pulse on top of the level flags, then let the reply land
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= meas_events_t'(m | lvl);
    @(posedge clk);
    ev <= meas_events_t'(lvl);
    repeat (5) @(posedge clk);
    #1;
  endtask
  initial begin
    void'($urandom(32'h729582f0));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    #1 chk("line", 32'(line), 32'h0);
    rd_reg(`OFS_CONFIG, v);
    chk("config", v, 32'h50);
    rd_reg(8'h20, v);
    chk("unmapped", v, 32'h0);
    wr_reg(`OFS_IRQ_MASK, 32'h3);
    pulse(8'h10);
    pulse(8'h20);
    rd_reg(`OFS_STATUS, v);
    chk("no check", v & 32'h3, 32'h0);
    lvl = 8'h01;
    for (int i = 0; i < 24; i++) begin
      pol = 1'($urandom % 2);
      md = 2'($urandom % 3);
      pc = 1'($urandom % 2);
      sc = 1'($urandom % 2);
      fl = 1'($urandom % 2);
      un = 1'($urandom % 2);
      exp_fail = fl || (pc && un);
      wr_reg(`OFS_CONFIG, {25'h0, 2'h2, sc, pc, md, pol});
      pulse(8'h10);
      if (md != 2'h0) chk("rest", 32'(line), 32'(md == 2'h1 ? pol : !pol));
      rd_reg(`OFS_STATUS, v);
      chk("busy", v & 32'h3, 32'h0);
      pulse(8'h04);
      if (un) pulse(8'h02);
      if (fl) pulse(8'h08);
      if (md == 2'h0 && fl) chk("at once", 32'(line), 32'(!pol));
      if (md != 2'h0) chk("held", 32'(line), 32'(md == 2'h1 ? pol : !pol));
      n0 = n_strobe;
      pulse(8'h40);
      chk("chan", 32'(n_strobe - n0), 32'(md != 2'h0 && !sc));
      pulse(8'h20);
      chk("strobed", 32'(n_strobe - n0), 32'h1);
      chk("verdict", 32'(vpin), 32'(exp_fail ? !pol : pol));
      rd_reg(`OFS_STATUS, v);
      chk("readout", v & 32'h3, exp_fail ? 32'h2 : 32'h1);
    end
    for (int k = 0; k < 3; k++) begin
      wr_reg(`OFS_CONFIG, {25'h0, 2'(k), 5'h10});
      pulse(8'h10);
      chk("sweep idle", 32'(sdn), 32'h1);
      n0 = n_sweep;
      pulse(8'h80 >> k);
      chk("sweep low", 32'(sdn), 32'h0);
      chk("sweep seen", 32'(n_sweep - n0), 32'h1);
    end
    wr_reg(`OFS_CONFIG, 32'h7f);
    rd_reg(`OFS_CONFIG, v);
    chk("code 3 refused", v, 32'h59);
    wr_reg(`OFS_CONFIG, 32'h0f);
    wr_reg(`OFS_COMMAND, 32'h1);
    rd_reg(`OFS_CONFIG, v);
    chk("restored", v, 32'h50);
    chk("sweep restored", 32'(sdn), 32'h1);
    wr_reg(`OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq masked", 32'(irq), 32'h0);
    wr_reg(`OFS_IRQ_MASK, 32'h3);
    repeat (2) @(posedge clk);
    #1 chk("irq set", 32'(irq), 32'h1);
    wr_reg(`OFS_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk);
    #1 chk("irq clear", 32'(irq), 32'h0);
    give_verdict();
  end
endmodule
